// ==== hdl/retire_event_pkg.sv ====
package retire_event_pkg;

  // counters 12..17 are local indices 0..5
  localparam int unsigned COUNTER_COUNT = 6;
  localparam int unsigned SELECTOR_COUNT = 4;
  localparam int unsigned TAG_SEL_COUNT = 2;
  localparam int unsigned REG_COUNT = SELECTOR_COUNT + TAG_SEL_COUNT + COUNTER_COUNT;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 32;

  // selector field layout
  localparam int unsigned CODE_MSB = 31;
  localparam int unsigned CODE_LSB = 25;
  localparam int unsigned MASK_MSB = 24;
  localparam int unsigned MASK_LSB = 9;
  // counter configuration field layout
  localparam int unsigned CCR_SEL_MSB = 15;
  localparam int unsigned CCR_SEL_LSB = 13;
  localparam int unsigned CCR_ENABLE_BIT = 12;

  // event select codes
  localparam logic [6:0] EV_UOP_TYPE = 7'h02;
  localparam logic [6:0] EV_BRANCH = 7'h06;
  localparam logic [6:0] EV_MISPRED = 7'h03;
  localparam logic [6:0] EV_FLOAT_ASSIST = 7'h03;

  // counter configuration select codes
  localparam logic [2:0] CCR_SEL_TAG = 3'h2;
  localparam logic [2:0] CCR_SEL_LOW = 3'h4;
  localparam logic [2:0] CCR_SEL_HIGH = 3'h5;

  // event mask bit positions
  localparam int unsigned load_mark_bit = 1;
  localparam int unsigned store_mark_bit = 2;
  localparam int unsigned not_taken_predicted_bit = 0;
  localparam int unsigned not_taken_mispredicted_bit = 1;
  localparam int unsigned taken_predicted_bit = 2;
  localparam int unsigned taken_mispredicted_bit = 3;
  localparam int unsigned genuine_retire_bit = 0;
  localparam int unsigned stack_underflow_assist_bit = 0;
  localparam int unsigned stack_overflow_assist_bit = 1;
  localparam int unsigned output_overflow_assist_bit = 2;
  localparam int unsigned output_underflow_assist_bit = 3;
  localparam int unsigned input_assist_bit = 4;

  // byte offsets
  localparam logic [7:0] OFF_RETIRE_SEL0 = 8'h00;
  localparam logic [7:0] OFF_RETIRE_SEL1 = 8'h04;
  localparam logic [7:0] OFF_RETIRE_SEL2 = 8'h08;
  localparam logic [7:0] OFF_RETIRE_SEL3 = 8'h0c;
  localparam logic [7:0] OFF_TAG_SEL0 = 8'h10;
  localparam logic [7:0] OFF_TAG_SEL1 = 8'h14;
  localparam logic [7:0] OFF_CCR12 = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam int unsigned IDX_TAG_SEL0 = 4;
  localparam int unsigned IDX_CCR12 = 6;
  localparam int unsigned IDX_STATUS = 12;
  localparam int unsigned STATUS_TAG_LOAD_BIT = 8;
  localparam int unsigned STATUS_TAG_STORE_BIT = 9;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_ack = 2'b01
  } bus_state_type;

  // counters 14, 15, 17 sit on the odd selector of each pair
  function automatic logic counter_side(input int unsigned idx);
    return (idx == 2) || (idx == 3) || (idx == 5);
  endfunction : counter_side

endpackage : retire_event_pkg

// ==== hdl/reg_word.sv ====
`timescale 1ns/10ps
module reg_word
  import retire_event_pkg::*;
#(
  parameter int unsigned WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write port
  input wire logic wr_en,
  input wire logic [WIDTH/8-1:0] byteenable,
  input wire logic [WIDTH-1:0] wdata,
  // stored value
  output logic [WIDTH-1:0] value_q
);
  logic [WIDTH-1:0] value_d;

  always_comb begin
    value_d = value_q;
    for (int b = 0; b < WIDTH / 8; b++) begin
      if (wr_en && byteenable[b]) begin
        value_d[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end
endmodule : reg_word

// ==== hdl/event_qualify.sv ====
`timescale 1ns/10ps
module event_qualify
  import retire_event_pkg::*;
(
  // counter configuration
  input wire logic enable,
  input wire logic [2:0] group,
  input wire logic [31:0] selector,
  // retirement report
  input wire logic branch_valid,
  input wire logic branch_taken,
  input wire logic branch_mispred,
  input wire logic branch_bogus,
  input wire logic assist_valid,
  input wire logic [4:0] assist_kind,
  // qualified increment
  output logic hit
);
  logic [6:0] code;
  logic [15:0] mask;
  logic [1:0] outcome;

  always_comb begin
    code = selector[CODE_MSB:CODE_LSB];
    mask = selector[MASK_MSB:MASK_LSB];
    outcome = {branch_taken, branch_mispred};
    hit = 1'b0;
    case (group)
      CCR_SEL_LOW: begin
        // only genuine mispredicted branches
        hit = (code == EV_MISPRED) && mask[genuine_retire_bit] && branch_valid && branch_mispred
              && !branch_bogus;
      end
      CCR_SEL_HIGH: begin
        if (code == EV_BRANCH) begin
          // outcome indexes the four mask bits: nt-pred, nt-mispred, t-pred, t-mispred
          hit = branch_valid && mask[outcome];
        end else if (code == EV_FLOAT_ASSIST) begin
          hit = assist_valid && (
            (mask[stack_underflow_assist_bit] && assist_kind[stack_underflow_assist_bit]) ||
            (mask[stack_overflow_assist_bit] && assist_kind[stack_overflow_assist_bit]) ||
            (mask[output_overflow_assist_bit] && assist_kind[output_overflow_assist_bit]) ||
            (mask[output_underflow_assist_bit] && assist_kind[output_underflow_assist_bit]) ||
            (mask[input_assist_bit] && assist_kind[input_assist_bit]));
        end
      end
      // tagging only marks micro-ops, it never counts
      CCR_SEL_TAG: hit = 1'b0;
      default: hit = 1'b0;
    endcase
    hit = hit && enable;
  end
endmodule : event_qualify

// ==== hdl/retirement_event_select.sv ====
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
//Contract
// - micro-op tagging uses event code 02H with configuration select 02H, and mask bit 1 marks loads.
// - in micro-op tagging, mask bit 2 marks stores.
// - the load and store tag bits never increment any counter on their own.
// - branch retirement uses event code 06H with select 05H and counts branches matching any enabled outcome.
// - branch mask bits: 0 not-taken predicted, 1 not-taken mispredicted, 2 taken predicted, 3 taken mispredicted.
// - branch and assist events come only from selectors 2 and 3, selector 2 feeding 12/13/16, 3 feeding 14/15/17.
// - code 03H with select 04H and mask bit 0 counts genuine mispredicted branches via selectors 0 and 1 only.
// - code 03H with select 05H counts retired x87 instructions needing any enabled kind of assist.
// - assist mask bit 0 selects stack underflow.
// - assist mask bit 1 selects stack overflow.
// - assist mask bit 2 selects output overflow and bit 3 output underflow.
// - assist mask bit 4 selects input operand assists.
module retirement_event_select
  import retire_event_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_WIDTH-1:0] avs_writedata,
  input wire logic [DATA_WIDTH/8-1:0] avs_byteenable,
  output logic [DATA_WIDTH-1:0] avs_readdata,
  output logic avs_waitrequest,
  // retirement report
  input wire logic branch_valid,
  input wire logic branch_taken,
  input wire logic branch_mispred,
  input wire logic branch_bogus,
  input wire logic assist_valid,
  input wire logic [4:0] assist_kind,
  input wire logic uop_valid,
  input wire logic uop_is_load,
  input wire logic uop_is_store,
  // counter increments and micro-op tags
  output logic [COUNTER_COUNT-1:0] count_inc,
  output logic uop_tag_load,
  output logic uop_tag_store
);
  bus_state_type state_q, state_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] reg_q [REG_COUNT];
  logic wr_fire;
  logic [3:0] word_idx;
  logic [31:0] read_mux;
  logic [31:0] status_w;
  logic [COUNTER_COUNT-1:0] hit_w;
  logic [COUNTER_COUNT-1:0] inc_q, inc_d;
  logic tag_load_q, tag_load_d, tag_store_q, tag_store_d;
  logic [TAG_SEL_COUNT-1:0] tag_side_used;

  function automatic logic [2:0] ccr_group(input logic [31:0] ccr);
    return ccr[CCR_SEL_MSB:CCR_SEL_LSB];
  endfunction : ccr_group

  assign word_idx = avs_address[5:2];
  // write lands on the edge where the master sees waitrequest low
  assign wr_fire = avs_write && (state_q == bus_ack);

  // register words: retire selectors, tag selectors, counter configurations
  for (genvar k = 0; k < REG_COUNT; k++) begin : g_regs
    reg_word #(
      .WIDTH(32),
      .RESET_VALUE(REG_RESET)
    ) u_word (
      .clk(clk),
      .resetn(resetn),
      .wr_en(wr_fire && (avs_address[7:6] == 2'b00) && (word_idx == 4'(k))),
      .byteenable(avs_byteenable),
      .wdata(avs_writedata),
      .value_q(reg_q[k])
    );
  end

  always_comb begin
    status_w = '0;
    status_w[COUNTER_COUNT-1:0] = inc_q;
    status_w[STATUS_TAG_LOAD_BIT] = tag_load_q;
    status_w[STATUS_TAG_STORE_BIT] = tag_store_q;
    read_mux = '0;
    if (avs_address[7:6] == 2'b00) begin
      if (word_idx < 4'(REG_COUNT)) begin
        read_mux = reg_q[word_idx];
      end else if (word_idx == 4'(IDX_STATUS)) begin
        read_mux = status_w;
      end
    end
  end

  // bus handshake: one wait cycle, then one cycle of waitrequest low
  always_comb begin
    state_d = state_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    case (state_q)
      bus_idle: begin
        if (avs_read || avs_write) begin
          state_d = bus_ack;
          wait_d = 1'b0;
          if (avs_read) begin
            rdata_d = read_mux;
          end
        end
      end
      bus_ack: state_d = bus_idle;
      default: state_d = bus_idle;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= bus_idle;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // per counter: pick the selector that its configuration names
  for (genvar i = 0; i < COUNTER_COUNT; i++) begin : g_counters
    logic [31:0] ccr;
    logic [2:0] grp;
    logic side;
    logic [31:0] chosen;
    assign ccr = reg_q[IDX_CCR12 + i];
    assign grp = ccr_group(ccr);
    assign side = counter_side(i);
    always_comb begin
      case (grp)
        CCR_SEL_LOW: chosen = reg_q[32'(side)];
        CCR_SEL_HIGH: chosen = reg_q[2 + 32'(side)];
        CCR_SEL_TAG: chosen = reg_q[IDX_TAG_SEL0 + 32'(side)];
        default: chosen = '0;
      endcase
    end
    event_qualify u_qualify (
      .enable(ccr[CCR_ENABLE_BIT]),
      .group(grp),
      .selector(chosen),
      .branch_valid(branch_valid),
      .branch_taken(branch_taken),
      .branch_mispred(branch_mispred),
      .branch_bogus(branch_bogus),
      .assist_valid(assist_valid),
      .assist_kind(assist_kind),
      .hit(hit_w[i])
    );
  end

  // a tag selector is live when an enabled counter on its side selects tagging
  always_comb begin
    tag_side_used = '0;
    for (int i = 0; i < COUNTER_COUNT; i++) begin
      if (reg_q[IDX_CCR12 + i][CCR_ENABLE_BIT] && (ccr_group(reg_q[IDX_CCR12 + i]) == CCR_SEL_TAG)) begin
        tag_side_used[counter_side(i)] = 1'b1;
      end
    end
  end

  always_comb begin
    inc_d = hit_w;
    tag_load_d = 1'b0;
    tag_store_d = 1'b0;
    for (int s = 0; s < TAG_SEL_COUNT; s++) begin
      if (tag_side_used[s] && (reg_q[IDX_TAG_SEL0 + s][CODE_MSB:CODE_LSB] == EV_UOP_TYPE)) begin
        if (uop_valid && uop_is_load && reg_q[IDX_TAG_SEL0 + s][MASK_LSB + load_mark_bit]) begin
          tag_load_d = 1'b1;
        end
        if (uop_valid && uop_is_store && reg_q[IDX_TAG_SEL0 + s][MASK_LSB + store_mark_bit]) begin
          tag_store_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inc_q <= '0;
      tag_load_q <= 1'b0;
      tag_store_q <= 1'b0;
    end else begin
      inc_q <= inc_d;
      tag_load_q <= tag_load_d;
      tag_store_q <= tag_store_d;
    end
  end

  assign count_inc = inc_q;
  assign uop_tag_load = tag_load_q;
  assign uop_tag_store = tag_store_q;

  // checks on counter 12 (local 0) and the bus
  logic [31:0] ccr0;
  logic [2:0] grp0;
  logic [15:0] mask_sel0, mask_sel2, mask_tag0;
  logic [6:0] code_sel0, code_sel2;
  assign ccr0 = reg_q[IDX_CCR12];
  assign grp0 = ccr0[CCR_SEL_MSB:CCR_SEL_LSB];
  assign mask_sel0 = reg_q[0][MASK_MSB:MASK_LSB];
  assign mask_sel2 = reg_q[2][MASK_MSB:MASK_LSB];
  assign mask_tag0 = reg_q[IDX_TAG_SEL0][MASK_MSB:MASK_LSB];
  assign code_sel0 = reg_q[0][CODE_MSB:CODE_LSB];
  assign code_sel2 = reg_q[2][CODE_MSB:CODE_LSB];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_request_waiting;
    (avs_read || avs_write) && avs_waitrequest && (state_q == bus_idle);
  endsequence
  sequence s_one_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer_one: assert property (s_request_waiting |=> s_one_answer)
    else $error("bus answer not exactly one cycle after request");
  a_read_back_sel: assert property (
    (avs_read && !avs_waitrequest && $past(avs_address) == OFF_RETIRE_SEL0) |-> avs_readdata == reg_q[0])
    else $error("selector read back mismatch");
  a_inc_needs_cause: assert property (
    count_inc[0] |-> $past(ccr0[CCR_ENABLE_BIT]) && $past(branch_valid || assist_valid))
    else $error("counter advanced without a retirement");
  a_tag_never_counts: assert property ($past(grp0 == CCR_SEL_TAG) |-> !count_inc[0])
    else $error("tag selection advanced a counter");
  a_branch_outcome_count: assert property (
    $past(ccr0[CCR_ENABLE_BIT] && grp0 == CCR_SEL_HIGH && code_sel2 == EV_BRANCH && branch_valid
          && mask_sel2[{branch_taken, branch_mispred}]) |-> count_inc[0])
    else $error("matching branch not counted");
  a_branch_mask_map: assert property (
    $past(grp0 == CCR_SEL_HIGH && code_sel2 == EV_BRANCH && branch_valid && branch_taken && !branch_mispred
          && !mask_sel2[taken_predicted_bit]) |-> !count_inc[0])
    else $error("taken predicted branch counted with its bit clear");
  a_low_no_branch: assert property (
    $past(grp0 == CCR_SEL_LOW && !(branch_valid && branch_mispred)) |-> !count_inc[0])
    else $error("low selector pair counted a non-mispredicted event");
  a_bogus_ignored: assert property (
    $past(grp0 == CCR_SEL_LOW && branch_bogus) |-> !count_inc[0])
    else $error("bogus mispredicted branch counted");
  a_genuine_counted: assert property (
    $past(ccr0[CCR_ENABLE_BIT] && grp0 == CCR_SEL_LOW && code_sel0 == EV_MISPRED && mask_sel0[genuine_retire_bit]
          && branch_valid && branch_mispred && !branch_bogus) |-> count_inc[0])
    else $error("genuine mispredicted branch not counted");
  a_assist_counted: assert property (
    $past(ccr0[CCR_ENABLE_BIT] && grp0 == CCR_SEL_HIGH && code_sel2 == EV_FLOAT_ASSIST && assist_valid
          && |(mask_sel2[4:0] & assist_kind)) |-> count_inc[0])
    else $error("enabled assist not counted");
  a_assist_underflow: assert property (
    $past(grp0 == CCR_SEL_HIGH && code_sel2 == EV_FLOAT_ASSIST && !branch_valid
          && assist_kind == 5'h01 && !mask_sel2[stack_underflow_assist_bit]) |-> !count_inc[0])
    else $error("stack underflow counted with its bit clear");
  a_assist_overflow: assert property (
    $past(grp0 == CCR_SEL_HIGH && code_sel2 == EV_FLOAT_ASSIST && !branch_valid
          && assist_kind == 5'h02 && !mask_sel2[stack_overflow_assist_bit]) |-> !count_inc[0])
    else $error("stack overflow counted with its bit clear");
  a_assist_output: assert property (
    $past(grp0 == CCR_SEL_HIGH && code_sel2 == EV_FLOAT_ASSIST && !branch_valid && assist_kind == 5'h0c
          && !mask_sel2[output_overflow_assist_bit] && !mask_sel2[output_underflow_assist_bit]) |-> !count_inc[0])
    else $error("output assist counted with its bits clear");
  a_assist_input: assert property (
    $past(grp0 == CCR_SEL_HIGH && code_sel2 == EV_FLOAT_ASSIST && !branch_valid
          && assist_kind == 5'h10 && !mask_sel2[input_assist_bit]) |-> !count_inc[0])
    else $error("input assist counted with its bit clear");
  a_load_tag_mark: assert property (
    $past(ccr0[CCR_ENABLE_BIT] && grp0 == CCR_SEL_TAG && reg_q[IDX_TAG_SEL0][CODE_MSB:CODE_LSB] == EV_UOP_TYPE
          && mask_tag0[load_mark_bit] && uop_valid && uop_is_load) |-> uop_tag_load)
    else $error("load micro-op not tagged");
  a_store_tag_mark: assert property (
    uop_tag_store |-> $past(uop_valid && uop_is_store))
    else $error("store tag without a store micro-op");
  a_store_tag_set: assert property (
    $past(ccr0[CCR_ENABLE_BIT] && grp0 == CCR_SEL_TAG && reg_q[IDX_TAG_SEL0][CODE_MSB:CODE_LSB] == EV_UOP_TYPE
          && mask_tag0[store_mark_bit] && uop_valid && uop_is_store) |-> uop_tag_store)
    else $error("store micro-op not tagged");
  a_load_tag_cause: assert property (
    uop_tag_load |-> $past(uop_valid && uop_is_load))
    else $error("load tag without a load micro-op");
  a_disabled_silent: assert property ($past(!ccr0[CCR_ENABLE_BIT]) |-> !count_inc[0])
    else $error("disabled counter advanced");
  a_high_other_code: assert property (
    $past(grp0 == CCR_SEL_HIGH && code_sel2 != EV_BRANCH && code_sel2 != EV_FLOAT_ASSIST) |-> !count_inc[0])
    else $error("high selector pair counted an unknown code");
  a_write_lands: assert property (
    $past(avs_write && !avs_waitrequest && avs_address == OFF_RETIRE_SEL0 && avs_byteenable == 4'hf)
    |-> reg_q[0] == $past(avs_writedata))
    else $error("selector write did not land");
  a_idle_waits: assert property ((state_q == bus_idle && !avs_read && !avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");
endmodule : retirement_event_select

// ==== sim/retire_source.sv ====
`timescale 1ns/10ps
module retire_source (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // command from the bench
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [4:0] cmd_bits,
  // retirement report
  output logic branch_valid,
  output logic branch_taken,
  output logic branch_mispred,
  output logic branch_bogus,
  output logic assist_valid,
  output logic [4:0] assist_kind,
  output logic uop_valid,
  output logic uop_is_load,
  output logic uop_is_store
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {branch_valid, assist_valid, uop_valid} <= 3'h0;
      {branch_bogus, branch_mispred, branch_taken} <= 3'h0;
      {uop_is_store, uop_is_load} <= 2'h0;
      assist_kind <= 5'h00;
    end else begin
      branch_valid <= cmd_valid && cmd_kind == 2'h1;
      assist_valid <= cmd_valid && cmd_kind == 2'h2;
      uop_valid <= cmd_valid && cmd_kind == 2'h3;
      if (cmd_valid) begin
        {branch_bogus, branch_mispred, branch_taken} <= cmd_bits[2:0];
        {uop_is_store, uop_is_load} <= cmd_bits[1:0];
        assist_kind <= cmd_bits;
      end else begin
        // attributes flip while no operation is reported, so stale values never look valid
        {branch_bogus, branch_mispred, branch_taken} <= ~{branch_bogus, branch_mispred, branch_taken};
        {uop_is_store, uop_is_load} <= ~{uop_is_store, uop_is_load};
        assist_kind <= ~assist_kind;
      end
    end
  end
endmodule : retire_source

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
module testbench
  import retire_event_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [4:0] cmd_bits = 5'h00;
  logic branch_valid, branch_taken, branch_mispred, branch_bogus, assist_valid;
  logic uop_valid, uop_is_load, uop_is_store, uop_tag_load, uop_tag_store;
  logic [4:0] assist_kind;
  logic [5:0] count_inc;
  logic [31:0] q;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  retirement_event_select uut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .branch_valid(branch_valid),
    .branch_taken(branch_taken), .branch_mispred(branch_mispred), .branch_bogus(branch_bogus),
    .assist_valid(assist_valid), .assist_kind(assist_kind), .uop_valid(uop_valid), .uop_is_load(uop_is_load),
    .uop_is_store(uop_is_store), .count_inc(count_inc), .uop_tag_load(uop_tag_load),
    .uop_tag_store(uop_tag_store));

  retire_source src (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_bits(cmd_bits), .branch_valid(branch_valid), .branch_taken(branch_taken),
    .branch_mispred(branch_mispred), .branch_bogus(branch_bogus), .assist_valid(assist_valid),
    .assist_kind(assist_kind), .uop_valid(uop_valid), .uop_is_load(uop_is_load), .uop_is_store(uop_is_store));

  task automatic end_of_test;
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // waits as long as the slave needs; only the bench ceiling ends a hung access
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'hf);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0, 4'hf);
    check(q, exp);
  endtask : rc

  function automatic logic [31:0] cfg(input logic [2:0] s);
    return (32'h1 << CCR_ENABLE_BIT) | (32'(s) << CCR_SEL_LSB);
  endfunction : cfg

  function automatic logic [31:0] esel(input logic [6:0] c, input logic [15:0] m);
    return {c, m, 9'h000};
  endfunction : esel

  task automatic all_cfg(input logic [31:0] v);
    for (int i = 0; i < 6; i++) wr(OFF_CCR12 + 8'(4 * i), v);
  endtask : all_cfg

  // report n back-to-back operations, then collect pulses for a few cycles
  task automatic fire(input logic [1:0] k, input logic [4:0] b, input int n, input logic [5:0] ei,
                      input logic [1:0] et);
    logic [5:0] acc;
    logic [1:0] tg;
    int hits;
    acc = 6'h00;
    tg = 2'h0;
    hits = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_bits <= b;
    repeat (n) @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (5) @(negedge clk) begin
      acc |= count_inc;
      tg |= {uop_tag_store, uop_tag_load};
      if (count_inc !== 6'h00) hits++;
    end
    check(32'(acc), 32'(ei));
    check(hits, (ei != 6'h00) ? n : 0);
    check(32'(tg), 32'(et));
  endtask : fire

  task automatic t_regs;
    for (int i = 0; i < 13; i++) rc(8'(4 * i), REG_RESET);
    rc(8'h34, 32'h0);
    bus(1'b0, OFF_RETIRE_SEL1, 32'hffff_ffff, 4'h3);
    rc(OFF_RETIRE_SEL1, 32'h0000_ffff);
    wr(8'h40, 32'hffff_ffff);
    rc(OFF_RETIRE_SEL0, 32'h0);
    rc(8'h40, 32'h0);
    wr(OFF_STATUS, 32'hffff_ffff);
    rc(OFF_STATUS, 32'h0);
    wr(OFF_RETIRE_SEL1, 32'h0);
  endtask : t_regs

  task automatic t_branch;
    all_cfg(cfg(CCR_SEL_HIGH));
    for (int b = 0; b < 4; b++) begin
      wr(OFF_RETIRE_SEL2, esel(EV_BRANCH, 16'(1 << b)));
      for (int o = 0; o < 4; o++) fire(2'h1, {3'h0, o[0], o[1]}, 1, (o == b) ? 6'h13 : 6'h00, 2'h0);
    end
    wr(OFF_RETIRE_SEL2, esel(EV_BRANCH, 16'h000f));
    fire(2'h1, 5'h01, 2, 6'h13, 2'h0);
    wr(OFF_RETIRE_SEL2, 32'h0);
    wr(OFF_RETIRE_SEL3, esel(EV_BRANCH, 16'h000f));
    fire(2'h1, 5'h02, 1, 6'h2c, 2'h0);
    wr(OFF_RETIRE_SEL0, esel(EV_BRANCH, 16'h000f));
    wr(OFF_RETIRE_SEL3, 32'h0);
    fire(2'h1, 5'h02, 1, 6'h00, 2'h0);
    wr(OFF_RETIRE_SEL0, 32'h0);
  endtask : t_branch

  task automatic t_mispred;
    all_cfg(cfg(CCR_SEL_LOW));
    wr(OFF_RETIRE_SEL0, esel(EV_MISPRED, 16'h0001));
    wr(OFF_RETIRE_SEL2, esel(EV_MISPRED, 16'h0001));
    fire(2'h1, 5'h02, 1, 6'h13, 2'h0);
    fire(2'h1, 5'h06, 1, 6'h00, 2'h0);
    fire(2'h1, 5'h01, 1, 6'h00, 2'h0);
    fire(2'h2, 5'h1f, 1, 6'h00, 2'h0);
    wr(OFF_RETIRE_SEL0, esel(EV_MISPRED, 16'h0002));
    fire(2'h1, 5'h02, 1, 6'h00, 2'h0);
    wr(OFF_RETIRE_SEL0, 32'h0);
    fire(2'h1, 5'h02, 1, 6'h00, 2'h0);
    wr(OFF_RETIRE_SEL2, 32'h0);
  endtask : t_mispred

  task automatic t_assist;
    all_cfg(cfg(CCR_SEL_HIGH));
    for (int k = 0; k < 5; k++) begin
      wr(OFF_RETIRE_SEL3, esel(EV_FLOAT_ASSIST, 16'(1 << k)));
      wr(OFF_RETIRE_SEL2, esel(EV_FLOAT_ASSIST, ~16'(1 << k)));
      fire(2'h2, 5'(1 << k), 1, 6'h2c, 2'h0);
      fire(2'h2, ~5'(1 << k), 1, 6'h13, 2'h0);
    end
    wr(OFF_RETIRE_SEL2, esel(EV_FLOAT_ASSIST, 16'h0013));
    fire(2'h2, 5'h0c, 1, 6'h00, 2'h0);
    fire(2'h1, 5'h03, 1, 6'h00, 2'h0);
    all_cfg(32'(CCR_SEL_HIGH) << CCR_SEL_LSB);
    fire(2'h2, 5'h10, 1, 6'h00, 2'h0);
    wr(OFF_RETIRE_SEL3, 32'h0);
    wr(OFF_RETIRE_SEL2, 32'h0);
    all_cfg(32'h0);
  endtask : t_assist

  task automatic t_tag;
    wr(OFF_CCR12, cfg(CCR_SEL_TAG));
    wr(OFF_TAG_SEL0, esel(EV_UOP_TYPE, 16'h0006));
    fire(2'h3, 5'h01, 1, 6'h00, 2'h1);
    fire(2'h3, 5'h02, 1, 6'h00, 2'h2);
    wr(OFF_TAG_SEL0, esel(EV_UOP_TYPE, 16'h0004));
    fire(2'h3, 5'h01, 1, 6'h00, 2'h0);
    wr(OFF_CCR12, 32'h0);
  endtask : t_tag

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_branch();
    t_mispred();
    t_assist();
    t_tag();
    end_of_test();
  end
endmodule : testbench
